// *** design/lpsd_core.sv ***
// Device-side command decode, burst engine and data path of a four-bank
// low-power SDRAM. Assumes the controller runs on core_clk and honours
// the spacings it owns; nothing here checks them.
//
// Operation
// - Dropping clock enable suspends or powers down one clock later.
// - Clock enable raised at least one clock before next command.
// - Write byte mask blocks data captured on the same edge.
// - Read byte mask floats the lanes two clocks later.
// - First write word captured with the write command.
// - Precharge during read floats outputs after CAS latency clocks.
// - First read word after CAS latency, then one per clock.
`default_nettype none

module lpsd_core #(
  parameter int AW = lpsd_pkg::LPSD_AW
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lpsd_pkg::lpsd_cmd_t cmd,
  input wire logic [lpsd_pkg::LPSD_LANES-1:0] dqm,
  input wire logic [lpsd_pkg::LPSD_DW-1:0] dq_in,
  output logic [lpsd_pkg::LPSD_DW-1:0] dq_out,
  output logic [lpsd_pkg::LPSD_LANES-1:0] dq_oe_n
);

  lpsd_pkg::lpsd_state_t s_reg;
  lpsd_pkg::lpsd_state_t s_next;
  lpsd_pkg::lpsd_op_t op;
  lpsd_pkg::lpsd_beat_t tap;
  logic [lpsd_pkg::LPSD_COL_W-1:0] bmask;
  logic cur_v;
  logic cur_wr;
  logic [1:0] cur_bank;
  logic [lpsd_pkg::LPSD_COL_W-1:0] cur_col;
  logic [AW-1:0] cur_addr;
  logic st_we;
  logic st_re;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic lpsd_pkg::lpsd_op_t decode(input lpsd_pkg::lpsd_cmd_t c);
    lpsd_pkg::lpsd_op_t o;
    o = lpsd_pkg::LPSD_OP_NOP;
    if (!c.cs_n)
    begin
      unique case ({c.ras_n, c.cas_n, c.we_n})
        3'h3: o = lpsd_pkg::LPSD_OP_ACT;
        3'h5: o = lpsd_pkg::LPSD_OP_RD;
        3'h4: o = lpsd_pkg::LPSD_OP_WR;
        3'h2: o = lpsd_pkg::LPSD_OP_PRE;
        3'h6: o = lpsd_pkg::LPSD_OP_BST;
        3'h1: o = lpsd_pkg::LPSD_OP_REF;
        3'h0: o = lpsd_pkg::LPSD_OP_MRS;
        3'h7: o = lpsd_pkg::LPSD_OP_NOP;
      endcase
    end
    return o;
  endfunction

  // Column wraps inside the burst window, as the burst order requires
  function automatic logic [lpsd_pkg::LPSD_COL_W-1:0] step_col(
    input logic [lpsd_pkg::LPSD_COL_W-1:0] col,
    input logic [lpsd_pkg::LPSD_COL_W-1:0] mask);
    logic [lpsd_pkg::LPSD_COL_W-1:0] inc;
    inc = col + 9'h001;
    return (col & ~mask) | (inc & mask);
  endfunction

  // Reserved burst codes behave as single beats
  always_comb
  begin
    unique case (s_reg.bl)
      3'h1: bmask = 9'h001;
      3'h2: bmask = 9'h003;
      3'h3: bmask = 9'h007;
      lpsd_pkg::LPSD_BL_FULL: bmask = lpsd_pkg::LPSD_PAGE_MASK;
      default: bmask = 9'h000;
    endcase
  end

  // ----------------------------------------------------------------
  // Command decode and burst engine
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    op = decode(cmd);
    cur_v = 1'b0;
    cur_wr = 1'b0;
    cur_bank = s_reg.bbank;
    cur_col = s_reg.bcol;
    cur_addr = '0;
    tap = '0;
    st_we = 1'b0;
    st_re = 1'b0;
    // Enable seen at the previous edge gates this edge
    s_next.cke_q = cmd.cke;
    if (s_reg.cke_q)
    begin
      st_re = 1'b1;
      s_next.dqm_d1 = dqm;
      // Running burst supplies this edge's beat
      if (s_reg.bact)
      begin
        cur_v = 1'b1;
        cur_wr = s_reg.bwr;
        if (s_reg.bleft == 9'h000)
        begin
          s_next.bact = 1'b0;
          if (s_reg.bap)
          begin
            s_next.open[s_reg.bbank] = 1'b0;
          end
        end
        else
        begin
          s_next.bcol = step_col(s_reg.bcol, bmask);
          if (s_reg.bl != lpsd_pkg::LPSD_BL_FULL)
          begin
            s_next.bleft = s_reg.bleft - 9'h001;
          end
        end
      end
      unique case (op)
        lpsd_pkg::LPSD_OP_ACT:
        begin
          s_next.open[cmd.ba] = 1'b1;
          s_next.row[cmd.ba] = cmd.addr[lpsd_pkg::LPSD_ROW_BITS-1:0];
        end
        lpsd_pkg::LPSD_OP_RD, lpsd_pkg::LPSD_OP_WR:
        begin
          // A new access truncates any running burst
          cur_v = 1'b1;
          cur_wr = (op == lpsd_pkg::LPSD_OP_WR);
          cur_bank = cmd.ba;
          cur_col = cmd.addr[lpsd_pkg::LPSD_COL_W-1:0];
          s_next.bwr = cur_wr;
          s_next.bap = cmd.addr[lpsd_pkg::LPSD_AP_BIT];
          s_next.bbank = cmd.ba;
          s_next.bcol = step_col(cur_col, bmask);
          // Command edge carries beat zero, so one fewer beat remains
          s_next.bleft = bmask - 9'h001;
          s_next.bact = (bmask != 9'h000);
          if (bmask == 9'h000 && cmd.addr[lpsd_pkg::LPSD_AP_BIT])
          begin
            s_next.open[cmd.ba] = 1'b0;
          end
        end
        lpsd_pkg::LPSD_OP_PRE:
        begin
          if (cmd.addr[lpsd_pkg::LPSD_AP_BIT])
          begin
            s_next.open = '0;
          end
          else
          begin
            s_next.open[cmd.ba] = 1'b0;
          end
          // Beat on this edge is dropped; lanes float CL clocks later
          if (s_reg.bact && (cmd.addr[lpsd_pkg::LPSD_AP_BIT] || cmd.ba == s_reg.bbank))
          begin
            cur_v = 1'b0;
            s_next.bact = 1'b0;
          end
        end
        lpsd_pkg::LPSD_OP_BST:
        begin
          cur_v = 1'b0;
          s_next.bact = 1'b0;
        end
        lpsd_pkg::LPSD_OP_MRS:
        begin
          // Unsupported latency codes leave the old value in place
          if (cmd.addr[lpsd_pkg::LPSD_CL_LSB +: 3] inside {lpsd_pkg::LPSD_CL_1, lpsd_pkg::LPSD_CL_2,
                                                          lpsd_pkg::LPSD_CL_3})
          begin
            s_next.cl = cmd.addr[lpsd_pkg::LPSD_CL_LSB +: 3];
          end
          s_next.bl = cmd.addr[lpsd_pkg::LPSD_BL_LSB +: 3];
        end
        lpsd_pkg::LPSD_OP_REF, lpsd_pkg::LPSD_OP_NOP:
        begin
        end
      endcase
      cur_addr = AW'({cur_bank, s_next.row[cur_bank], cur_col[lpsd_pkg::LPSD_COL_BITS-1:0]});
      st_we = cur_v && cur_wr;

      // ------------------------------------------------------------
      // Read latency pipeline
      // ------------------------------------------------------------
      s_next.p1.v = cur_v && !cur_wr;
      s_next.p1.addr = cur_addr;
      s_next.p2 = s_reg.p1;
      unique case (s_reg.cl)
        lpsd_pkg::LPSD_CL_1: tap = s_next.p1;
        lpsd_pkg::LPSD_CL_2: tap = s_reg.p1;
        default: tap = s_reg.p2;
      endcase
      // A write command clears read data still in flight
      if (op == lpsd_pkg::LPSD_OP_WR)
      begin
        tap.v = 1'b0;
        s_next.p1.v = 1'b0;
        s_next.p2.v = 1'b0;
      end
      // Mask seen one edge ago plus this output flop gives two clocks
      s_next.oe_n = tap.v ? s_reg.dqm_d1 : '1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= lpsd_pkg::LPSD_STATE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Data array
  // ----------------------------------------------------------------
  lpsd_store #(
    .AW(AW),
    .LANES(lpsd_pkg::LPSD_LANES)
  ) u_store (
    .core_clk(core_clk),
    .we(st_we),
    .wmask(dqm),
    .waddr(cur_addr),
    .wdata(dq_in),
    .re(st_re),
    .raddr(tap.addr),
    .rdata(dq_out)
  );

  assign dq_oe_n = s_reg.oe_n;

endmodule

`default_nettype wire

// *** design/lpsd_pkg.sv ***
// Shared types and constants for the low-power SDRAM command/timing core.
// Assumes one 200 MHz clock shared with the memory controller.
`default_nettype none

package lpsd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int LPSD_CLK_PS = 5000;

  // Least times round up to whole cycles
  function automatic int lpsd_min_cyc(input int ns);
    return (ns * 1000 + LPSD_CLK_PS - 1) / LPSD_CLK_PS;
  endfunction

  localparam int LPSD_T_RCD_NS = 18;
  localparam int LPSD_T_RAS_MIN_NS = 48;
  localparam int LPSD_T_RAS_MAX_NS = 100000;
  localparam int LPSD_T_RC_NS = 60;
  localparam int LPSD_T_RRD_NS = 12;
  localparam int LPSD_T_WR_NS = 15;
  localparam int LPSD_T_XSR_NS = 80;
  localparam int LPSD_T_RCD_CYC = lpsd_min_cyc(LPSD_T_RCD_NS);
  localparam int LPSD_T_RAS_MIN_CYC = lpsd_min_cyc(LPSD_T_RAS_MIN_NS);
  localparam int LPSD_T_RC_CYC = lpsd_min_cyc(LPSD_T_RC_NS);
  localparam int LPSD_T_RRD_CYC = lpsd_min_cyc(LPSD_T_RRD_NS);
  localparam int LPSD_T_WR_CYC = lpsd_min_cyc(LPSD_T_WR_NS);
  localparam int LPSD_T_XSR_CYC = lpsd_min_cyc(LPSD_T_XSR_NS);
  localparam int LPSD_T_CCD_CYC = 1;
  localparam int LPSD_T_CKED_CYC = 1;
  localparam int LPSD_T_PED_CYC = 1;
  localparam int LPSD_T_DQM_CYC = 0;
  localparam int LPSD_T_DQZ_CYC = 2;
  localparam int LPSD_T_DWD_CYC = 0;
  localparam int LPSD_T_DPL_CYC = 2;
  localparam int LPSD_T_BDL_CYC = 1;
  localparam int LPSD_T_CDL_CYC = 1;
  localparam int LPSD_T_MRD_CYC = 2;

  // ----------------------------------------------------------------
  // Geometry and field positions
  // ----------------------------------------------------------------
  localparam int LPSD_BANKS = 4;
  localparam int LPSD_LANES = 4;
  localparam int LPSD_DW = 32;
  localparam int LPSD_ADDR_W = 13;
  localparam int LPSD_COL_W = 9;
  localparam int LPSD_ROW_BITS = 2;
  localparam int LPSD_COL_BITS = 4;
  localparam int LPSD_AW = 2 + LPSD_ROW_BITS + LPSD_COL_BITS;
  localparam int LPSD_AP_BIT = 10;
  localparam int LPSD_CL_LSB = 4;
  localparam int LPSD_BL_LSB = 0;

  // ----------------------------------------------------------------
  // Mode register codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] LPSD_CL_1 = 3'h1;
  localparam logic [2:0] LPSD_CL_2 = 3'h2;
  localparam logic [2:0] LPSD_CL_3 = 3'h3;
  localparam logic [2:0] LPSD_BL_FULL = 3'h7;
  localparam logic [2:0] LPSD_CL_RESET = 3'h3;
  localparam logic [2:0] LPSD_BL_RESET = 3'h2;
  localparam logic [LPSD_COL_W-1:0] LPSD_PAGE_MASK = 9'h1ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [LPSD_ADDR_W-1:0] addr;
  } lpsd_cmd_t;

  typedef enum logic [2:0] {
    LPSD_OP_NOP,
    LPSD_OP_ACT,
    LPSD_OP_RD,
    LPSD_OP_WR,
    LPSD_OP_PRE,
    LPSD_OP_BST,
    LPSD_OP_REF,
    LPSD_OP_MRS
  } lpsd_op_t;

  typedef struct packed {
    logic v;
    logic [LPSD_AW-1:0] addr;
  } lpsd_beat_t;

  typedef struct packed {
    logic cke_q;
    logic [2:0] cl;
    logic [2:0] bl;
    logic [LPSD_BANKS-1:0] open;
    logic [LPSD_BANKS-1:0][LPSD_ROW_BITS-1:0] row;
    logic bact;
    logic bwr;
    logic bap;
    logic [1:0] bbank;
    logic [LPSD_COL_W-1:0] bcol;
    logic [LPSD_COL_W-1:0] bleft;
    lpsd_beat_t p1;
    lpsd_beat_t p2;
    logic [LPSD_LANES-1:0] dqm_d1;
    logic [LPSD_LANES-1:0] oe_n;
  } lpsd_state_t;

  localparam lpsd_state_t LPSD_STATE_RESET = '{
    cke_q: 1'b0, cl: LPSD_CL_RESET, bl: LPSD_BL_RESET, open: 4'h0, row: '0,
    bact: 1'b0, bwr: 1'b0, bap: 1'b0, bbank: 2'h0, bcol: 9'h000, bleft: 9'h000,
    p1: '0, p2: '0, dqm_d1: 4'h0, oe_n: 4'hf
  };

endpackage

`default_nettype wire

// *** design/lpsd_store.sv ***
// Small data array behind the SDRAM core, byte-lane masked writes.
// Assumes writes and reads are issued by the core on the same clock.
`default_nettype none

module lpsd_store #(
  parameter int AW = lpsd_pkg::LPSD_AW,
  parameter int LANES = lpsd_pkg::LPSD_LANES
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [LANES-1:0] wmask,
  input wire logic [AW-1:0] waddr,
  input wire logic [LANES*8-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [LANES*8-1:0] rdata
);

  // ----------------------------------------------------------------
  // Per-lane write and registered read
  // ----------------------------------------------------------------
  // Each lane owns its array; the lanes share only rdata, each writing its own byte slice
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic [7:0] mem [2**AW];

    always_ff @(posedge core_clk)
    begin
      if (we && !wmask[g])
      begin
        mem[waddr] <= wdata[g*8 +: 8];
      end
      if (re)
      begin
        rdata[g*8 +: 8] <= mem[raddr];
      end
    end
  end

endmodule

`default_nettype wire

// *** test/lp_sdram_command_timing_tb.sv ***
// Self-checking bench for the SDRAM command/timing core.
// Assumes the controller model and the bound checker compile alongside.
`default_nettype none

module lp_sdram_command_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  lpsd_pkg::lpsd_cmd_t cmd;
  logic [3:0] dqm;
  logic [31:0] dq_in;
  logic [31:0] dq_out;
  logic [3:0] dq_oe_n;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] mem [256];

  always #2.5 core_clk = ~core_clk;

  lpsd_ctl_model ctl_u (.core_clk(core_clk), .cmd(cmd), .dqm(dqm), .dq_in(dq_in));
  lpsd_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lanes(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  // Row is the inverted bank; columns wrap inside the aligned window of four
  function automatic logic [7:0] word(input logic [1:0] ba, input logic [3:0] col, input int i);
    return {ba, ~ba, col[3:2], col[1:0] + 2'(i)};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_wr(input logic [1:0] ba, input logic [3:0] col, input logic p, input logic sus);
    logic [31:0] d;
    logic [3:0] m;
    logic [7:0] a;
    logic stop;
    if (sus)
      ctl_u.cyc(3'h7, ba, 13'h0000, 4'h0, ~dq_in, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      m = p ? 4'($urandom) : 4'h0;
      a = word(ba, col, i);
      // Masked pass at the top column stops the burst before its last word
      stop = p && !sus && col == 4'hf && i == 3;
      ctl_u.cyc(i == 0 ? 3'h4 : (stop ? 3'h6 : 3'h7), ba, {9'h000, col}, m, d, 1'b1);
      if (!sus && !stop)
        mem[a] = (mem[a] & lanes(m)) | (d & ~lanes(m));
    end
  endtask

  task automatic do_rd(input logic [1:0] ba, input logic [3:0] col, input int cl, input int s, input logic p);
    logic [3:0] rm [0:8];
    logic [3:0] e;
    int b;
    foreach (rm[k])
      rm[k] = (p && k > 0) ? 4'($urandom) : 4'h0;
    ctl_u.cyc(3'h5, ba, {9'h000, col}, 4'h0, ~dq_in, 1'b1);
    for (int k = 1; k <= cl + 4; k++)
    begin
      ctl_u.cyc(k == s ? 3'h2 : 3'h7, ba, 13'h0400, rm[k], ~dq_in, 1'b1);
      @(negedge core_clk);
      b = k - cl;
      e = (b >= 0 && b < 4 && k < s + cl) ? ~(k >= 2 ? rm[k-2] : 4'h0) : 4'h0;
      cmp({28'h0, dq_oe_n}, {28'h0, ~e});
      cmp(dq_out & lanes(e), mem[word(ba, col, b)] & lanes(e));
    end
  endtask

  task automatic end_sim();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----
  // Sequence: clean pass, then masked pass with early precharge
  // ----
  initial
  begin
    void'($urandom(32'h5674));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    ctl_u.init();
    for (int p = 0; p < 2; p++)
      for (int cl = 1; cl <= 3; cl++)
      begin
        ctl_u.cyc(3'h0, 2'h0, {6'h00, 3'(cl), 4'h2}, 4'h0, ~dq_in, 1'b1);
        ctl_u.gap(lpsd_pkg::LPSD_T_MRD_CYC);
        ctl_u.cyc(3'h3, 2'(cl), {11'h000, ~2'(cl)}, 4'h0, ~dq_in, 1'b1);
        ctl_u.gap(lpsd_pkg::LPSD_T_RCD_CYC);
        do_wr(2'(cl), 4'(cl * 5), p[0], p == 1 && cl == 2);
        ctl_u.gap(lpsd_pkg::LPSD_T_DPL_CYC);
        do_rd(2'(cl), 4'(cl * 5), cl, p == 1 ? $urandom_range(1, 3) : 99, p[0]);
        // Fully masked write keeps the data but closes the row by itself
        if (p == 0)
        begin
          ctl_u.cyc(3'h4, 2'(cl), {2'h0, 1'b1, 5'h00, 5'(cl * 5)}, 4'hf, ~dq_in, 1'b1);
          repeat (3) ctl_u.cyc(3'h7, 2'h0, 13'h0000, 4'hf, ~dq_in, 1'b1);
          ctl_u.gap(lpsd_pkg::LPSD_T_WR_CYC);
        end
        ctl_u.gap(lpsd_pkg::LPSD_T_RAS_MIN_CYC);
        ctl_u.cyc(3'h2, 2'h0, 13'h0400, 4'h0, ~dq_in, 1'b1);
        ctl_u.gap(lpsd_pkg::LPSD_T_RC_CYC);
        $display("test pass=%0d cl=%0d done", p, cl);
      end
    end_sim();
  end

  // Power-up wait dominates; the rest is a few hundred cycles
  initial
  begin
    repeat (45000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end
endmodule

`default_nettype wire

// *** test/lpsd_core_props.sv ***
// Timing checker for the SDRAM core, sees only the core's ports.
// Assumes one clock; tracks latency and burst length from mode loads.
`default_nettype none

module lpsd_core_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lpsd_pkg::lpsd_cmd_t cmd,
  input wire logic [3:0] dqm,
  input wire logic [31:0] dq_in,
  input wire logic [31:0] dq_out,
  input wire logic [3:0] dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cke_q;
  logic [2:0] cl_q;
  logic [2:0] bl_q;
  logic [2:0] z_cnt;
  logic [2:0] rcw;
  logic taken;
  logic rd_t;
  logic wr_t;
  logic pre_all;
  logic mrs;
  logic quiet;

  assign rcw = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign taken = !cmd.cs_n && cke_q;
  assign rd_t = taken && rcw == 3'h5;
  assign wr_t = taken && rcw == 3'h4;
  assign pre_all = taken && rcw == 3'h2 && cmd.addr[10];
  assign mrs = taken && rcw == 3'h0;
  assign quiet = cmd.cs_n && cmd.cke && dqm == 4'h0;

  // Countdown to float after precharge all; any command or stall cancels it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cke_q <= 1'b0;
      cl_q <= 3'h3;
      bl_q <= 3'h2;
      z_cnt <= 3'h0;
    end
    else
    begin
      cke_q <= cmd.cke;
      if (mrs && cmd.addr[6:4] inside {3'h1, 3'h2, 3'h3})
        cl_q <= cmd.addr[6:4];
      if (mrs)
        bl_q <= cmd.addr[2:0];
      if (pre_all && cmd.cke)
        z_cnt <= cl_q;
      else if (taken || !cmd.cke)
        z_cnt <= 3'h0;
      else if (z_cnt != 3'h0)
        z_cnt <= z_cnt - 3'h1;
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_first_cl1: assert property (rd_t && cl_q == 3'h1 && $past(dqm) == 4'h0 |=> dq_oe_n == 4'h0)
    else $error("first beat missing at latency one");
  chk_first_cl2: assert property (rd_t && cmd.cke && cl_q == 3'h2 && dqm == 4'h0 ##1 quiet |=> dq_oe_n == 4'h0)
    else $error("first beat missing at latency two");
  chk_first_cl3: assert property (rd_t && cmd.cke && cl_q == 3'h3 ##1 quiet[*2] |=> dq_oe_n == 4'h0)
    else $error("first beat missing at latency three");
  chk_burst_run: assert property (rd_t && cmd.cke && cl_q == 3'h2 && bl_q == 3'h2 && dqm == 4'h0 ##1 quiet[*5]
    |=> dq_oe_n == 4'hf && $past(dq_oe_n) == 4'h0 && $past(dq_oe_n, 4) == 4'h0)
    else $error("burst of four not driven for four cycles");
  chk_mask_float: assert property (cke_q && cmd.cke && dqm != 4'h0
    |-> ##2 (dq_oe_n & $past(dqm, 2)) == $past(dqm, 2))
    else $error("masked lane driven two clocks after mask");
  chk_write_float: assert property (wr_t |=> dq_oe_n == 4'hf)
    else $error("lanes driven after write command");
  chk_pre_float: assert property (z_cnt == 3'h1 |-> dq_oe_n == 4'hf)
    else $error("lanes driven after precharge latency");
  chk_suspend_hold: assert property (!cmd.cke |-> ##2 $stable(dq_oe_n))
    else $error("output enable moved in suspended cycle");

  cov_read: cover property (rd_t);
  cov_pre_all: cover property (pre_all);
  cov_suspend: cover property (!cmd.cke ##1 (!cmd.cs_n && !cke_q));
endmodule

bind lpsd_core lpsd_core_props chk_u (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .dqm(dqm), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n));

`default_nettype wire

// *** test/lpsd_ctl_model.sv ***
// Controller stand-in driving command, mask and write data pins.
// Assumes the bench calls its tasks in sequence from one process.
`default_nettype none

module lpsd_ctl_model (
  input wire logic core_clk,
  output lpsd_pkg::lpsd_cmd_t cmd,
  output logic [3:0] dqm,
  output logic [31:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: 13'h0000};
    dqm = 4'h0;
    dq_in = 32'h0000_0000;
  end

  // ----
  // Bus slots
  // ----
  // Idle data lines toggle so stale data is never mistaken for a write
  task automatic cyc(input logic [2:0] rcw, input logic [1:0] ba, input logic [12:0] a, input logic [3:0] m,
    input logic [31:0] d, input logic ke);
    @(posedge core_clk);
    cmd <= '{cke: ke, cs_n: rcw == 3'h7, ras_n: rcw[2], cas_n: rcw[1], we_n: rcw[0], ba: ba, addr: a};
    dqm <= m;
    dq_in <= d;
  endtask

  // Random stretch stands in for a slow controller
  task automatic gap(input int n);
    repeat (n + $urandom_range(0, 2)) cyc(3'h7, 2'h0, 13'h0000, 4'h0, ~dq_in, 1'b1);
  endtask

  task automatic init();
    repeat (40000) @(posedge core_clk);
    repeat (2)
    begin
      cyc(3'h1, 2'h0, 13'h0000, 4'h0, ~dq_in, 1'b1);
      gap(16);
    end
    // Self refresh entry and exit; the clock keeps running throughout
    cyc(3'h1, 2'h0, 13'h0000, 4'h0, ~dq_in, 1'b0);
    repeat (4) cyc(3'h7, 2'h0, 13'h0000, 4'h0, ~dq_in, 1'b0);
    gap(lpsd_pkg::LPSD_T_XSR_CYC);
  endtask
endmodule

`default_nettype wire
